// File: rtl/repeater_pkg.sv
// constants shared by the repeater core: timing in bit times, apb map, field layout.
// assumes a 250 mhz pclk and a 10 mb/s line (100 ns per bit).
package repeater_pkg;
  localparam int N_PORTS = 5; // port 0 is the attachment-unit port, 1..4 twisted pair
  localparam int AUI_PORT = 0;
  // bit timing
  localparam int BIT_NS = 100; // one bit time at 10 mb/s
  localparam int CLK_NS = 4; // pclk period
  localparam int CYC_PER_BIT = (BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] BIT_LAST = 5'(CYC_PER_BIT - 1);
  // packet shaping, in bit times
  localparam logic [6:0] PREAMBLE_BITS = 7'h38; // 56
  localparam logic [6:0] MIN_FRAME_BITS = 7'h60; // 96
  localparam logic [6:0] LOCK_BITS = 7'h60; // 96
  localparam int JABBER_BITS_DEF = 65536;
  // partition and reconnection, in bit times or attempts
  localparam logic [11:0] COLL_RUN_BITS = 12'h800; // 2048
  localparam logic [5:0] ATTEMPT_LIMIT = 6'h20; // 32
  localparam logic [9:0] RECON_BITS = 10'h200; // 512
  // strap capture waits out the synchroniser after reset release
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // apb register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] EVENT_OFS = 8'h08;
  // ctrl fields
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_ALT_TP_BIT = 8;
  localparam int CTRL_ALT_AUI_BIT = 9;
  localparam logic [4:0] PORT_EN_RST = 5'h1f;
  // status fields
  localparam int ST_PART_LSB = 0;
  localparam int ST_LOCK_BIT = 8;
  localparam int ST_REVERSE_BIT = 9;
  localparam int ST_POLAUTO_BIT = 10;
  localparam int ST_EXPSEL_LSB = 11;
  localparam int ST_SINGLE_BIT = 13;
  localparam int ST_CHAIN_BIT = 14;
  localparam int ST_LINKTEST_BIT = 15;
  localparam int ST_LINKFAIL_LSB = 16;
  // event fields, write one to clear
  localparam int EV_LOCK_BIT = 0;
  typedef enum logic [1:0] {ST_IDLE, ST_REPEAT, ST_JAM, ST_LOCK} rep_state_t;
endpackage

// File: rtl/ethernet_repeater_core.sv
// core of a five-port 10 mb/s repeater: repeat, regenerate, jam, jabber lockout, partitioning.
// assumes line receivers deliver recovered carrier and data as async levels, and an apb master on pclk.
//
// What this block does
// - repeat single valid receiver to other enabled ports
// - drive repeated data onto expansion data line
// - at least 56 preamble bits before delimiter
// - lock transmit 96 bits after 65536 continuous
// - keep readable lockup status indication
// - jam short fragments out to 96 bits
// - partitioned ports still transmit; receive cannot start a repeat but still counts toward contention
// - partition after collision over 2048 bits
// - partition after 32 consecutive colliding attempts
// - collision: sqe on aui, tx+rx on tp
// - standard: reconnect after clean 512-bit tx/rx
// - alternative: reconnect only after clean 512-bit tx
// - disable then enable clears partition
// - one algorithm for tp, separate for aui
// - partition state kept per port, independently
// - reset loads defaults, idles outputs, releases lines
// - sample straps and chained inputs at reset release
// - direction strap low normal, high reverse
// - reset defaults: serial out high, lines released
// - serial input high disables polarity correction
`timescale 1ns/1ps
`default_nettype none
module ethernet_repeater_core
  import repeater_pkg::*;
#(
  parameter int JABBER_BITS = JABBER_BITS_DEF // shorten for simulation
)(
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port receive side, async levels
  input wire logic [4:0] rx_crs,
  input wire logic [4:0] rx_data,
  input wire logic sqe_in,
  // port transmit side
  output logic [4:0] tx_en,
  output logic [4:0] tx_data,
  // expansion lines, split into out/enable
  output logic expansion_data_line_o,
  output logic expansion_data_line_oe,
  output logic exp_jam_o,
  output logic exp_jam_oe,
  // straps and chained inputs, sampled after reset release
  input wire logic [1:0] expansion_select_strap,
  input wire logic serial_in,
  input wire logic sense_chain_in,
  input wire logic chain_serial_in,
  input wire logic aui_direction_strap,
  // mode outputs
  output logic serial_out,
  output logic ci_reverse,
  output logic polarity_auto_en,
  output logic transmit_lockup_protection
);

  // popcount of the five port flags, used for start and contention
  function automatic logic [2:0] count5(input logic [4:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int k = 0; k < N_PORTS; k++)
      n = n + {2'h0, v[k]};
    return n;
  endfunction

  // lowest set port index
  function automatic logic [2:0] first5(input logic [4:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int k = N_PORTS - 1; k >= 0; k--)
      if (v[k])
        n = 3'(k);
    return n;
  endfunction

  // valid register address
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == CTRL_OFS) || (a == STATUS_OFS) || (a == EVENT_OFS);
  endfunction

  localparam int JAB_W = $clog2(JABBER_BITS + 2);
  localparam logic [JAB_W-1:0] JAB_LIMIT = JAB_W'(JABBER_BITS);
  localparam int SYNC_W = 17;

  logic [SYNC_W-1:0] meta_reg; // first stage, read by second stage only
  logic [SYNC_W-1:0] sync_reg; // safe copies
  logic [4:0] rx_crs_s, rx_data_s; // synchronised port inputs
  logic sqe_s;
  logic [4:0] bit_cnt_reg; // divider position
  logic bit_tick; // one pulse per bit time
  logic [1:0] settle_reg; // strap capture delay
  logic [5:0] strap_reg; // captured straps
  logic [4:0] port_en_reg; // software port enables
  logic alt_tp_reg, alt_aui_reg; // reconnection selections
  logic lockup_seen_reg; // sticky lockup event
  logic [4:0] part_reg; // partitioned ports
  rep_state_t state_reg; // repeater state
  logic [2:0] src_reg; // receiving port
  logic coll_reg; // jam is a collision jam
  logic [6:0] out_cnt_reg; // bits sent this packet, saturates
  logic [6:0] lock_cnt_reg; // lockout length
  logic [JAB_W-1:0] jab_cnt_reg; // continuous transmit length
  logic [4:0] act; // ports eligible to start a repeat
  logic [2:0] n_act; // how many carriers compete
  logic start_ok; // a single clean start
  logic contention; // more than one carrier
  logic jab_over; // transmitted too long
  logic acc_wr; // apb write at access edge

  // two-flop synchroniser for every port, strap and chained pin input; apb pins are not synchronised
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= {aui_direction_strap, chain_serial_in, sense_chain_in, serial_in,
                   expansion_select_strap, sqe_in, rx_crs, rx_data};
      sync_reg <= meta_reg;
    end
  end
  assign rx_data_s = sync_reg[4:0];
  assign rx_crs_s = sync_reg[9:5];
  assign sqe_s = sync_reg[10];

  // bit-time divider; a plain count of pclk keeps every timer on one clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bit_cnt_reg <= '0;
    else if (bit_cnt_reg == BIT_LAST)
      bit_cnt_reg <= '0;
    else
      bit_cnt_reg <= bit_cnt_reg + 5'h1;
  end
  assign bit_tick = (bit_cnt_reg == BIT_LAST);

  // strap capture a few cycles after release, once the synchroniser holds real pin levels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      settle_reg <= '0;
      strap_reg <= '0;
    end
    else if (settle_reg != STRAP_SETTLE)
    begin
      settle_reg <= settle_reg + 2'h1;
      if (settle_reg + 2'h1 == STRAP_SETTLE)
        strap_reg <= sync_reg[16:11];
    end
  end

  // mode outputs: reverse and polarity from captured straps, serial out fixed high; reset shows normal mode, correction off
  assign ci_reverse = strap_reg[5];
  assign polarity_auto_en = (settle_reg == STRAP_SETTLE) && !strap_reg[2];
  assign serial_out = 1'b1;
  assign transmit_lockup_protection = (state_reg == ST_LOCK);

  // start and contention detection; partitioned receivers never start a repeat
  assign act = rx_crs_s & port_en_reg & ~part_reg;
  assign n_act = count5(act);
  assign start_ok = (n_act == 3'h1);
  assign contention = (count5(rx_crs_s & port_en_reg) > 3'h1);
  assign jab_over = (jab_cnt_reg > JAB_LIMIT);

  // repeater state machine, advanced once per bit time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      src_reg <= '0;
      coll_reg <= 1'b0;
      out_cnt_reg <= '0;
      lock_cnt_reg <= '0;
    end
    else if (bit_tick)
    begin
      if (out_cnt_reg != 7'h7f)
        out_cnt_reg <= out_cnt_reg + 7'h1;
      unique case (state_reg)
        ST_IDLE:
        begin
          out_cnt_reg <= '0;
          coll_reg <= 1'b0;
          if (start_ok)
          begin
            state_reg <= ST_REPEAT;
            src_reg <= first5(act);
          end
        end
        ST_REPEAT:
        begin
          if (jab_over)
            state_reg <= ST_LOCK;
          else if (contention)
          begin
            state_reg <= ST_JAM;
            coll_reg <= 1'b1;
          end
          else if (!rx_crs_s[src_reg])
            // the bit sent on this tick already counts toward the minimum length
            state_reg <= (out_cnt_reg < MIN_FRAME_BITS - 7'h1) ? ST_JAM : ST_IDLE;
        end
        ST_JAM:
        begin
          // collision jam runs while any carrier stays; both kinds reach 96 bits
          if (jab_over)
            state_reg <= ST_LOCK;
          else if (out_cnt_reg >= MIN_FRAME_BITS - 7'h1 && !(coll_reg && |(rx_crs_s & port_en_reg)))
            state_reg <= ST_IDLE;
        end
        ST_LOCK:
        begin
          if (lock_cnt_reg == LOCK_BITS - 7'h1)
            state_reg <= ST_IDLE;
        end
      endcase
      lock_cnt_reg <= (state_reg == ST_LOCK) ? lock_cnt_reg + 7'h1 : '0;
    end
  end

  // continuous transmit length for the jabber guard
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      jab_cnt_reg <= '0;
    else if (bit_tick)
    begin
      if (state_reg == ST_REPEAT || state_reg == ST_JAM)
      begin
        if (!jab_over)
          jab_cnt_reg <= jab_cnt_reg + JAB_W'(1);
      end
      else
        jab_cnt_reg <= '0;
    end
  end

  // transmit and expansion outputs; preamble bits are regenerated, not copied
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_en <= '0;
      tx_data <= '0;
      expansion_data_line_o <= 1'b0;
      expansion_data_line_oe <= 1'b0;
      exp_jam_o <= 1'b0;
      exp_jam_oe <= 1'b0;
    end
    else if (bit_tick)
    begin
      // a tripped jabber guard goes quiet on the tick lockout begins, not one bit later
      unique case (jab_over ? ST_LOCK : state_reg)
        ST_REPEAT:
        begin
          // partitioned ports still get traffic; only the source and disabled ports are skipped
          tx_en <= port_en_reg & ~(5'h1 << src_reg);
          if (out_cnt_reg < PREAMBLE_BITS)
            tx_data <= {5{~out_cnt_reg[0]}};
          else
            tx_data <= {5{rx_data_s[src_reg]}};
          expansion_data_line_oe <= 1'b1;
          expansion_data_line_o <= (out_cnt_reg < PREAMBLE_BITS) ? ~out_cnt_reg[0] : rx_data_s[src_reg];
          exp_jam_oe <= 1'b0;
          exp_jam_o <= 1'b0;
        end
        ST_JAM:
        begin
          // a collision jam also goes back to the source
          tx_en <= coll_reg ? port_en_reg : port_en_reg & ~(5'h1 << src_reg);
          tx_data <= {5{~out_cnt_reg[0]}};
          expansion_data_line_oe <= 1'b1;
          expansion_data_line_o <= ~out_cnt_reg[0];
          exp_jam_oe <= 1'b1;
          exp_jam_o <= coll_reg;
        end
        default:
        begin
          // idle and lockout both leave every line quiet
          tx_en <= '0;
          tx_data <= '0;
          expansion_data_line_oe <= 1'b0;
          expansion_data_line_o <= 1'b0;
          exp_jam_oe <= 1'b0;
          exp_jam_o <= 1'b0;
        end
      endcase
    end
  end

  // per-port partition and reconnection, one independent copy per port
  genvar gi;
  generate
    for (gi = 0; gi < N_PORTS; gi++)
    begin : g_port
      logic coll_now; // collision at this port
      logic alt_sel; // alternative reconnection for this port
      logic activity; // activity counted toward reconnection
      logic [11:0] crun_reg; // uninterrupted collision length
      logic [5:0] att_reg; // consecutive colliding attempts
      logic att_coll_reg; // current attempt saw a collision
      logic tx_prev_reg; // transmit level last bit
      logic act_prev_reg; // activity level last bit
      logic [9:0] rec_reg; // clean activity length
      logic rec_bad_reg; // activity saw a collision
      assign coll_now = (gi == AUI_PORT) ? sqe_s : (tx_en[gi] && rx_crs_s[gi]);
      assign alt_sel = (gi == AUI_PORT) ? alt_aui_reg : alt_tp_reg;
      assign activity = tx_en[gi] || (!alt_sel && rx_crs_s[gi]);

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          part_reg[gi] <= 1'b0;
          crun_reg <= '0;
          att_reg <= '0;
          att_coll_reg <= 1'b0;
          tx_prev_reg <= 1'b0;
          act_prev_reg <= 1'b0;
          rec_reg <= '0;
          rec_bad_reg <= 1'b0;
        end
        else if (!port_en_reg[gi])
        begin
          // a disabled port forgets its partition and its history
          part_reg[gi] <= 1'b0;
          crun_reg <= '0;
          att_reg <= '0;
          att_coll_reg <= 1'b0;
          rec_reg <= '0;
          rec_bad_reg <= 1'b0;
        end
        else if (bit_tick)
        begin
          tx_prev_reg <= tx_en[gi];
          act_prev_reg <= activity;
          crun_reg <= coll_now ? ((crun_reg == 12'hfff) ? crun_reg : crun_reg + 12'h1) : '0;
          att_coll_reg <= tx_en[gi] ? (att_coll_reg | coll_now) : 1'b0;
          if (tx_prev_reg && !tx_en[gi])
            att_reg <= att_coll_reg ? att_reg + 6'h1 : '0;
          rec_reg <= activity ? ((rec_reg == 10'h3ff) ? rec_reg : rec_reg + 10'h1) : '0;
          rec_bad_reg <= activity ? (rec_bad_reg | coll_now) : 1'b0;
          if (crun_reg > COLL_RUN_BITS || att_reg == ATTEMPT_LIMIT)
          begin
            part_reg[gi] <= 1'b1;
            att_reg <= '0;
          end
          else if (act_prev_reg && !activity && !rec_bad_reg && rec_reg > RECON_BITS)
            part_reg[gi] <= 1'b0;
        end
      end

      property p_part_run;
        @(posedge pclk) disable iff (!presetn)
        bit_tick && port_en_reg[gi] && crun_reg > COLL_RUN_BITS |=> part_reg[gi];
      endproperty
      a_part_run: assert property (p_part_run) else $error("long collision did not partition the port");
      property p_attempts;
        @(posedge pclk) disable iff (!presetn)
        bit_tick && port_en_reg[gi] && att_reg == ATTEMPT_LIMIT |=> part_reg[gi];
      endproperty
      a_attempts: assert property (p_attempts) else $error("colliding attempts did not partition the port");
      property p_reenable;
        @(posedge pclk) disable iff (!presetn)
        !port_en_reg[gi] |=> !part_reg[gi];
      endproperty
      a_reenable: assert property (p_reenable) else $error("disabled port kept its partition");
    end
  endgenerate

  // apb slave: zero wait states, read data staged in the setup cycle
  assign acc_wr = psel && penable && pwrite && addr_ok(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);

  // control register and write-one-to-clear event; a new lockup beats a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_en_reg <= PORT_EN_RST;
      alt_tp_reg <= 1'b0;
      alt_aui_reg <= 1'b0;
      lockup_seen_reg <= 1'b0;
    end
    else
    begin
      if (acc_wr && paddr == CTRL_OFS)
      begin
        port_en_reg <= pwdata[CTRL_EN_LSB +: N_PORTS];
        alt_tp_reg <= pwdata[CTRL_ALT_TP_BIT];
        alt_aui_reg <= pwdata[CTRL_ALT_AUI_BIT];
      end
      if (state_reg == ST_LOCK)
        lockup_seen_reg <= 1'b1;
      else if (acc_wr && paddr == EVENT_OFS && pwdata[EV_LOCK_BIT])
        lockup_seen_reg <= 1'b0;
    end
  end

  // read data register; unmapped addresses read zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable)
    begin
      prdata <= '0;
      if (paddr == CTRL_OFS)
      begin
        prdata[CTRL_EN_LSB +: N_PORTS] <= port_en_reg;
        prdata[CTRL_ALT_TP_BIT] <= alt_tp_reg;
        prdata[CTRL_ALT_AUI_BIT] <= alt_aui_reg;
      end
      else if (paddr == STATUS_OFS)
      begin
        prdata[ST_PART_LSB +: N_PORTS] <= part_reg;
        prdata[ST_LOCK_BIT] <= (state_reg == ST_LOCK);
        prdata[ST_REVERSE_BIT] <= strap_reg[5];
        prdata[ST_POLAUTO_BIT] <= polarity_auto_en;
        prdata[ST_EXPSEL_LSB +: 2] <= strap_reg[1:0];
        prdata[ST_SINGLE_BIT] <= strap_reg[3];
        prdata[ST_CHAIN_BIT] <= strap_reg[4];
        prdata[ST_LINKTEST_BIT] <= 1'b1; // link test enabled
        prdata[ST_LINKFAIL_LSB +: 4] <= 4'hf; // link logic lives outside this core
      end
      else if (paddr == EVENT_OFS)
        prdata[EV_LOCK_BIT] <= lockup_seen_reg;
    end
  end

  // checks next to the repeater logic
  property p_start;
    @(posedge pclk) disable iff (!presetn)
    bit_tick && state_reg == ST_IDLE && start_ok |=> state_reg == ST_REPEAT && src_reg == $past(first5(act));
  endproperty
  a_start: assert property (p_start) else $error("single carrier did not start a repeat");
  property p_no_echo;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_REPEAT)[*2] |-> !tx_en[src_reg];
  endproperty
  a_no_echo: assert property (p_no_echo) else $error("source port echoed its own data");
  property p_exp_drive;
    @(posedge pclk) disable iff (!presetn)
    bit_tick && !jab_over && state_reg == ST_REPEAT |=>
      expansion_data_line_oe && expansion_data_line_o == tx_data[0];
  endproperty
  a_exp_drive: assert property (p_exp_drive) else $error("expansion line not driven with data");
  property p_preamble;
    @(posedge pclk) disable iff (!presetn)
    bit_tick && state_reg == ST_REPEAT && out_cnt_reg < PREAMBLE_BITS |=> expansion_data_line_o == !$past(out_cnt_reg[0]);
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble bit not regenerated");
  property p_jabber;
    @(posedge pclk) disable iff (!presetn)
    bit_tick && jab_over && (state_reg == ST_REPEAT || state_reg == ST_JAM) |=> state_reg == ST_LOCK;
  endproperty
  a_jabber: assert property (p_jabber) else $error("long transmission not locked out");
  property p_lock_quiet;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_LOCK)[*2] |-> tx_en == 5'h0 && transmit_lockup_protection;
  endproperty
  a_lock_quiet: assert property (p_lock_quiet) else $error("transmitter active during lockout");
  property p_lock_status;
    @(posedge pclk) disable iff (!presetn)
    state_reg == ST_LOCK |=> lockup_seen_reg;
  endproperty
  a_lock_status: assert property (p_lock_status) else $error("lockup event not recorded");
  property p_lock_len;
    @(posedge pclk) disable iff (!presetn)
    bit_tick && state_reg == ST_LOCK && lock_cnt_reg < LOCK_BITS - 7'h1 |=> state_reg == ST_LOCK;
  endproperty
  a_lock_len: assert property (p_lock_len) else $error("lockout ended early");
  property p_fragment;
    @(posedge pclk) disable iff (!presetn)
    bit_tick && state_reg == ST_REPEAT && !jab_over && !contention && !rx_crs_s[src_reg]
      && out_cnt_reg < MIN_FRAME_BITS - 7'h1 |=> state_reg == ST_JAM;
  endproperty
  a_fragment: assert property (p_fragment) else $error("short fragment not extended");

  c_repeat: cover property (@(posedge pclk) disable iff (!presetn) state_reg == ST_REPEAT ##1 state_reg == ST_IDLE);
  c_frag: cover property (@(posedge pclk) disable iff (!presetn) state_reg == ST_JAM && !coll_reg);
  c_lock: cover property (@(posedge pclk) disable iff (!presetn) state_reg == ST_LOCK);
  c_part: cover property (@(posedge pclk) disable iff (!presetn) part_reg != 5'h0);

endmodule
`default_nettype wire

// File: dv/link_partner.sv
// twisted-pair link model: one frame per go, regenerated-style preamble then payload.
// assumes the bench supplies payload bits and a pclk from which bit time derives.
`timescale 1ns/1ps
`default_nettype none
module link_partner
  import repeater_pkg::*;
(
  input wire logic pclk,
  input wire logic go,
  input wire logic [4:0] mask,
  input wire logic [15:0] nbits,
  input wire logic pay,
  output logic [4:0] rx_crs,
  output logic [4:0] rx_data,
  output logic busy
);
  logic bit_v = 1'b1; // bit now on the line
  logic idle_t = 1'b0; // released lines toggle so no stale level survives
  logic [4:0] m_reg = 5'h0; // ports sending this frame
  int cyc = 0;
  int bits = 0;
  initial busy = 1'b0;
  // one bit per bit time; 62 alternating bits, then payload
  always @(posedge pclk)
  begin
    idle_t <= !idle_t;
    if (go && !busy)
    begin
      busy <= 1'b1;
      m_reg <= mask;
      cyc <= 0;
      bits <= 0;
      bit_v <= 1'b1;
    end
    else if (busy)
    begin
      cyc <= (cyc == CYC_PER_BIT - 1) ? 0 : cyc + 1;
      if (cyc == CYC_PER_BIT - 1)
      begin
        bits <= bits + 1;
        bit_v <= (bits < 61) ? !bit_v : pay;
        if (bits + 1 >= int'(nbits))
          busy <= 1'b0;
      end
    end
  end
  assign rx_crs = busy ? m_reg : 5'h0;
  assign rx_data = busy ? ((m_reg & {5{bit_v}}) | (~m_reg & {5{idle_t}})) : {5{idle_t}};
endmodule
`default_nettype wire

// File: dv/testbench.sv
// bench: apb registers, repeat, preamble, fragment jam, jabber lockout.
// assumes a zero-wait apb slave and link_partner on the receive side.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import repeater_pkg::*;
;
  localparam int JB = 200; // shortened jabber count
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rnd = 32'h955bf48a, w;
  logic pready, pslverr, busy, exp_o, exp_oe, jam_o, jam_oe, ser_o, ci_rev, pol, lockout, eoe;
  logic go = 1'b0;
  logic sqe = 1'b0;
  logic pin_lo = 1'b0; // low straps for the second reset
  logic [4:0] mask = 5'h0;
  logic [15:0] nbits = 16'h0;
  logic [4:0] rx_crs, rx_data, tx_en, tx_data, first;
  logic [33:0] exp_q[$]; // {read, slverr, data} noted by the apb driver
  int n_fail = 0;
  int check_count = 0;
  int act, lk, bad;
  always #2 pclk = !pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  always @(posedge pclk)
    rnd <= lfsr(rnd);
  ethernet_repeater_core #(.JABBER_BITS(JB)) ethernet_repeater_core_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_crs(rx_crs), .rx_data(rx_data), .sqe_in(sqe), .tx_en(tx_en),
    .tx_data(tx_data), .expansion_data_line_o(exp_o), .expansion_data_line_oe(exp_oe), .exp_jam_o(jam_o),
    .exp_jam_oe(jam_oe), .expansion_select_strap(2'b10), .serial_in(!pin_lo), .sense_chain_in(1'b1),
    .chain_serial_in(1'b0), .aui_direction_strap(!pin_lo), .serial_out(ser_o), .ci_reverse(ci_rev),
    .polarity_auto_en(pol), .transmit_lockup_protection(lockout));
  link_partner link_partner_inst (.pclk(pclk), .go(go), .mask(mask), .nbits(nbits), .pay(rnd[0]),
    .rx_crs(rx_crs), .rx_data(rx_data), .busy(busy));
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic hang();
    n_fail++;
    $display("MISMATCH %0t wait timed out", $time);
    close_out();
  endtask
  // one apb transfer; the monitor below compares what was noted
  task automatic apb(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic e,
    input logic [31:0] x);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= !rd;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back({rd, e, x});
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
      hang();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // retire the oldest note at each completed access
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      chk({31'h0, pslverr}, {31'h0, exp_q[0][32]}, "slverr");
      if (exp_q[0][33])
        chk(prdata, exp_q[0][31:0], "read data");
      void'(exp_q.pop_front());
    end
  // start a frame, then watch transmit activity until all is quiet
  task automatic send(input logic [4:0] m, input logic [15:0] nb);
    int n;
    n = 0;
    act = 0;
    lk = 0;
    bad = 0;
    mask <= m;
    nbits <= nb;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    while ((busy !== 1'b0 || tx_en !== 5'h0 || n < 300) && n < 20000)
    begin
      @(negedge pclk);
      n++;
      lk += (lockout === 1'b1);
      bad += (lockout === 1'b1 && tx_en !== 5'h0);
      if (tx_en !== 5'h0)
      begin
        if (act == 0)
          {first, eoe} = {tx_en, exp_oe};
        act++;
        if (act % CYC_PER_BIT == 12 && act / CYC_PER_BIT < 56)
          chk({26'h0, exp_o, tx_data & first},
            (act / CYC_PER_BIT) % 2 ? 32'h0 : {26'h0, 1'b1, first}, "preamble");
      end
    end
    if (n >= 20000)
      hang();
    @(posedge pclk); // later drives start just after a rising edge
  endtask
  initial
  begin
    repeat (5) @(negedge pclk); // reset held, shortened for simulation
    chk({23'h0, tx_en, exp_oe, jam_oe, lockout, ser_o}, 32'h1, "reset outputs");
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(negedge pclk);
    chk({30'h0, ci_rev, pol}, 32'h2, "strap modes");
    @(posedge pclk);
    apb(1, STATUS_OFS, 0, 0, 32'h000fb200);
    apb(1, CTRL_OFS, 0, 0, 32'h1f);
    apb(1, 8'h0c, 0, 1, 0);
    apb(0, 8'h0c, 32'hffffffff, 1, 0);
    send(5'h02, 120);
    chk({27'h0, first}, 32'h1d, "repeat ports");
    chk({31'h0, eoe}, 32'h1, "expansion drive");
    send(5'h04, 40);
    chk((act + 12) / CYC_PER_BIT, MIN_FRAME_BITS, "fragment length");
    send(5'h06, 120);
    chk(act, 0, "contention");
    apb(0, CTRL_OFS, 32'h1d, 0, 0);
    send(5'h02, 120);
    chk(act, 0, "disabled source");
    send(5'h08, 120);
    chk({27'h0, first}, 32'h15, "enabled ports");
    w = (rnd & 32'h300) | 32'h1f;
    apb(0, CTRL_OFS, w, 0, 0);
    apb(1, CTRL_OFS, 0, 0, w);
    send(5'h10, 16'(JB + 150));
    chk((lk + 12) / CYC_PER_BIT, LOCK_BITS, "lockout length");
    chk(bad, 0, "quiet in lockout");
    apb(1, EVENT_OFS, 0, 0, 32'h1);
    apb(0, EVENT_OFS, 32'h1, 0, 0);
    apb(1, EVENT_OFS, 0, 0, 32'h0);
    sqe <= 1'b1; // aui collision held past the partition limit
    repeat (2052 * CYC_PER_BIT) @(posedge pclk);
    sqe <= 1'b0;
    apb(1, STATUS_OFS, 0, 0, 32'h000fb201);
    apb(0, CTRL_OFS, 32'h1e, 0, 0);
    apb(0, CTRL_OFS, 32'h1f, 0, 0);
    apb(1, STATUS_OFS, 0, 0, 32'h000fb200);
    pin_lo <= 1'b1;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(negedge pclk);
    chk({30'h0, ci_rev, pol}, 32'h1, "low strap modes");
    close_out();
  end
endmodule
`default_nettype wire
